//--- hdl/uepset_params.svh
// Register offsets, field positions, reset values and list of behaviours for endpoint setup.
// Assumes an 8-bit register port with one-cycle read latency.
// Function
// RQ1: One control endpoint and five general endpoints, each bulk, interrupt or isochronous.
// RQ2: Alarm enables present up to fifteen IN and fifteen OUT endpoints.
// RQ3: Tokens to endpoints not active in the five slots get NAK and a flag.
// RQ4: Control endpoint shares one register set and area; firmware sets direction.
// RQ5: Firmware sets control max packet to 8, 16, 32 or 64, high speed 64.
// RQ6: Control endpoint area must exceed its max packet size.
// RQ7: Program area, clear it, then join; no data moves before join.
// RQ8: Firmware joins the control endpoint to area zero.
// RQ9: Each general endpoint has its own direction select bit.
// RQ10: Bulk max packet 8 to 64 at full speed, 512 at high speed.
// RQ11: Each general endpoint has a number 0x1 to 0xF matched against tokens.
// RQ12: Toggle mode bit is zero for bulk and OUT interrupt endpoints.
// RQ13: Isochronous bit is one for isochronous, zero for bulk or interrupt.
// RQ14: General endpoint area must be at least its max packet size.
// RQ15: Endpoint k binds only to area k; unused endpoints cannot be joined.
// RQ16: Firmware programs setup at init and on interface change.
// RQ17: Setup functions act only while device role is selected.
// RQ18: Enabled endpoint with unjoined area answers NAK.
// RQ19: Reset clears all joins and disables all general endpoints.
`ifndef UEPSET_PARAMS_SVH
`define UEPSET_PARAMS_SVH
`define UEPSET_ROLE        8'h00
`define UEPSET_CTRL_MPS    8'h01
`define UEPSET_CTRL_DIR    8'h02
`define UEPSET_ALARM_IN_L  8'h04
`define UEPSET_ALARM_IN_H  8'h05
`define UEPSET_ALARM_OUT_L 8'h06
`define UEPSET_ALARM_OUT_H 8'h07
`define UEPSET_NAK_STAT    8'h08
`define UEPSET_CTRL_BASE   8'h40
`define UEPSET_EP_BASE     8'h10
`define UEPSET_EP_STRIDE   4'h8
`define UEPSET_CFG         3'h0
`define UEPSET_MPS_H       3'h1
`define UEPSET_MPS_L       3'h2
`define UEPSET_ST_H        3'h3
`define UEPSET_ST_L        3'h4
`define UEPSET_END_H       3'h5
`define UEPSET_END_L       3'h6
`define UEPSET_JOIN        3'h7
`define UEPSET_CFG_DIR     7
`define UEPSET_CFG_EN      6
`define UEPSET_CFG_TOG     5
`define UEPSET_CFG_ISO     4
`define UEPSET_CTRL_MPS_RST 8'h40
`endif

//--- hdl/uepset_pkg.sv
// Types shared by the endpoint setup block.
// Assumes nothing beyond the tool.
package uepset_pkg;
  typedef enum logic [1:0] {
    UEPSET_ANS_NONE = 2'b00,
    UEPSET_ANS_GO   = 2'b01,
    UEPSET_ANS_NAK  = 2'b10
  } uepset_ans_t;
endpackage

//--- hdl/uepset_slot.sv
// One general endpoint slot: configuration, area bounds and area binding.
// Assumes the parent decodes writes and a synchronous active-high reset.
`timescale 1ns/1ps
`include "uepset_params.svh"
module uepset_slot (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       we_i,
  input  wire logic [2:0] reg_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       clear_i,
  input  wire logic [2:0] rreg_i,
  output logic      [7:0] rdata_o,
  output logic            enabled_o,
  output logic            in_dir_o,
  output logic      [3:0] number_o,
  output logic            joined_o
);
  logic [7:0] cfg_q, mps_h_q, mps_l_q, st_h_q, st_l_q, end_h_q, end_l_q;
  logic       join_q;
  logic       cleared_q;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cfg_q     <= 8'h00; // RQ19
      mps_h_q   <= 8'h00;
      mps_l_q   <= 8'h00;
      st_h_q    <= 8'h00;
      st_l_q    <= 8'h00;
      end_h_q   <= 8'h00;
      end_l_q   <= 8'h00;
      join_q    <= 1'b0; // RQ19
      cleared_q <= 1'b0;
    end else begin
      if (we_i && reg_i == `UEPSET_CFG) cfg_q <= wdata_i; // RQ9
      if (we_i && reg_i == `UEPSET_MPS_H) mps_h_q <= wdata_i;
      if (we_i && reg_i == `UEPSET_MPS_L) mps_l_q <= wdata_i;
      if (we_i && reg_i == `UEPSET_ST_H) st_h_q <= wdata_i;
      if (we_i && reg_i == `UEPSET_ST_L) st_l_q <= wdata_i;
      if (we_i && reg_i == `UEPSET_END_H) end_h_q <= wdata_i;
      if (we_i && reg_i == `UEPSET_END_L) end_l_q <= wdata_i;
      // Moving the area bounds forces a fresh clear before the next join.
      if (we_i && reg_i >= `UEPSET_ST_H && reg_i <= `UEPSET_END_L) begin
        cleared_q <= 1'b0; // RQ7
        join_q    <= 1'b0;
      end else if (clear_i) begin
        cleared_q <= 1'b1; // RQ7
      end
      if (we_i && reg_i == `UEPSET_JOIN) begin
        join_q <= wdata_i[0] & cfg_q[`UEPSET_CFG_EN] & (clear_i | cleared_q); // RQ15
      end else if (!cfg_q[`UEPSET_CFG_EN]) begin
        join_q <= 1'b0; // RQ15
      end
    end
  end
  assign enabled_o = cfg_q[`UEPSET_CFG_EN];
  assign in_dir_o  = cfg_q[`UEPSET_CFG_DIR];
  assign number_o  = cfg_q[3:0];
  assign joined_o  = join_q;
  always_comb begin
    unique case (rreg_i)
      `UEPSET_CFG:   rdata_o = cfg_q;
      `UEPSET_MPS_H: rdata_o = mps_h_q;
      `UEPSET_MPS_L: rdata_o = mps_l_q;
      `UEPSET_ST_H:  rdata_o = st_h_q;
      `UEPSET_ST_L:  rdata_o = st_l_q;
      `UEPSET_END_H: rdata_o = end_h_q;
      `UEPSET_END_L: rdata_o = end_l_q;
      `UEPSET_JOIN:  rdata_o = {6'h00, cleared_q, join_q};
    endcase
  end
endmodule

//--- hdl/uepset_top.sv
// Endpoint setup and area binding for the device side of a USB controller.
// Assumes the transaction engine presents one token per cycle as a pulse.
`timescale 1ns/1ps
`include "uepset_params.svh"
module uepset_top #(
  parameter int NUM_EP = 5
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  input  wire logic [7:0]           addr_i,
  input  wire logic [7:0]           wdata_i,
  input  wire logic                 write_i,
  input  wire logic                 read_i,
  output logic      [7:0]           rdata_o,
  input  wire logic                 token_i,
  input  wire logic [3:0]           token_ep_i,
  input  wire logic                 token_in_i,
  output logic                      ans_go_o,
  output logic                      ans_nak_o,
  output logic      [2:0]           ans_slot_o,
  output logic                      ctrl_in_dir_o,
  output logic                      ctrl_joined_o,
  output logic      [NUM_EP-1:0]    area_clear_o,
  output logic                      alarm_o
);
  import uepset_pkg::*;
  logic       role_device_q;
  logic [7:0] ctrl_mps_q;
  logic       ctrl_dir_q;
  logic [7:0] c_st_h_q, c_st_l_q, c_end_h_q, c_end_l_q;
  logic       c_join_q, c_cleared_q;
  logic [15:0] alarm_in_q, alarm_out_q;
  logic [7:0] nak_stat_q;
  logic [7:0] rdata_q;
  uepset_ans_t ans_q;
  logic [2:0] slot_q;
  logic [NUM_EP-1:0] clr_q;
  logic       alarm_q;
  wire        dev_mode = role_device_q; // RQ17
  wire        wr_dev = write_i & dev_mode;
  wire        in_ep_win = addr_i >= `UEPSET_EP_BASE;
  wire [7:0]  ep_off = addr_i - `UEPSET_EP_BASE;
  wire [4:0]  ep_sel = ep_off[7:3];
  wire [2:0]  ep_reg = ep_off[2:0];
  wire        ctrl_win = addr_i >= `UEPSET_CTRL_BASE && addr_i < `UEPSET_CTRL_BASE + 8'h08;
  wire [NUM_EP-1:0] en_w, dir_w, join_w, hit_w;
  wire [3:0]  num_w [NUM_EP];
  wire [7:0]  rd_w [NUM_EP];
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_ep
      wire sel = in_ep_win && !ctrl_win && ep_sel == 5'(g + 1);
      uepset_slot u_slot (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .we_i      (wr_dev & sel),
        .reg_i     (ep_reg),
        .wdata_i   (wdata_i),
        .clear_i   (wr_dev & sel & ep_reg == `UEPSET_JOIN & wdata_i[1]),
        .rreg_i    (ep_reg),
        .rdata_o   (rd_w[g]),
        .enabled_o (en_w[g]),
        .in_dir_o  (dir_w[g]),
        .number_o  (num_w[g]),
        .joined_o  (join_w[g])
      );
      // Token matching against each active slot's number and direction.
      assign hit_w[g] = en_w[g] && num_w[g] == token_ep_i && dir_w[g] == token_in_i; // RQ11
    end
  endgenerate
  // Control window for area zero sits above the last slot, so no slot loses its window.
  wire [2:0] c_reg = addr_i[2:0];
  wire       c_wr = wr_dev & ctrl_win;
  wire       c_clr = c_wr & c_reg == `UEPSET_JOIN & wdata_i[1];
  // Priority encoder picks the lowest matching slot.
  logic [2:0] hit_idx;
  logic       hit_any;
  always_comb begin
    hit_idx = 3'h0;
    hit_any = 1'b0;
    for (int i = NUM_EP - 1; i >= 0; i--) begin
      if (hit_w[i]) begin
        hit_idx = 3'(i + 1);
        hit_any = 1'b1;
      end
    end
  end
  wire [2:0] hit_slot = hit_idx - 3'h1;
  wire       hit_joined = hit_any && join_w[hit_slot];
  wire       is_ctrl = token_ep_i == 4'h0;
  wire       alarm_en = token_in_i ? alarm_in_q[token_ep_i] : alarm_out_q[token_ep_i];
  // A token to endpoint zero only moves data once area zero is joined.
  wire       go_w = dev_mode && token_i && (is_ctrl ? c_join_q : hit_joined); // RQ7
  wire       nak_w = dev_mode && token_i && !go_w; // RQ3
  wire       alarm_w = nak_w && !is_ctrl && !hit_any; // RQ3
  wire       nak_join_w = nak_w && (is_ctrl || hit_any); // RQ18
  // Sticky status: bit0 unjoined NAK, bit1 alarm on enabled alarm endpoint, bit2 alarm.
  wire [7:0] nak_set = {5'h00, alarm_w, alarm_w & alarm_en, nak_join_w};
  wire       nak_clr_w = wr_dev && addr_i == `UEPSET_NAK_STAT;
  wire [7:0] nak_d = (nak_clr_w ? (nak_stat_q & ~wdata_i) : nak_stat_q) | nak_set;
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (addr_i == `UEPSET_ROLE) begin
      rd_mux = {7'h00, role_device_q};
    end else if (!dev_mode) begin
      rd_mux = 8'h00; // RQ17
    end else if (ctrl_win) begin
      unique case (c_reg)
        `UEPSET_ST_H:  rd_mux = c_st_h_q;
        `UEPSET_ST_L:  rd_mux = c_st_l_q;
        `UEPSET_END_H: rd_mux = c_end_h_q;
        `UEPSET_END_L: rd_mux = c_end_l_q;
        `UEPSET_JOIN:  rd_mux = {6'h00, c_cleared_q, c_join_q};
        default:       rd_mux = 8'h00;
      endcase
    end else if (in_ep_win && ep_sel >= 5'h01 && ep_sel <= 5'(NUM_EP)) begin
      rd_mux = rd_w[3'(ep_sel - 5'h01)];
    end else begin
      unique case (addr_i)
        `UEPSET_CTRL_MPS:   rd_mux = ctrl_mps_q;
        `UEPSET_CTRL_DIR:   rd_mux = {7'h00, ctrl_dir_q};
        `UEPSET_ALARM_IN_L: rd_mux = alarm_in_q[7:0];
        `UEPSET_ALARM_IN_H: rd_mux = alarm_in_q[15:8];
        `UEPSET_ALARM_OUT_L: rd_mux = alarm_out_q[7:0];
        `UEPSET_ALARM_OUT_H: rd_mux = alarm_out_q[15:8];
        `UEPSET_NAK_STAT:   rd_mux = nak_stat_q;
        default:            rd_mux = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      role_device_q <= 1'b0;
      ctrl_mps_q    <= `UEPSET_CTRL_MPS_RST;
      ctrl_dir_q    <= 1'b0;
      alarm_in_q    <= 16'h0000;
      alarm_out_q   <= 16'h0000;
      nak_stat_q    <= 8'h00;
      rdata_q       <= 8'h00;
    end else begin
      if (write_i && addr_i == `UEPSET_ROLE) role_device_q <= wdata_i[0];
      if (wr_dev && addr_i == `UEPSET_CTRL_MPS) ctrl_mps_q <= wdata_i;
      if (wr_dev && addr_i == `UEPSET_CTRL_DIR) ctrl_dir_q <= wdata_i[0]; // RQ4
      // Endpoint zero of the alarm set is the control pipe and stays off.
      if (wr_dev && addr_i == `UEPSET_ALARM_IN_L) alarm_in_q[7:0] <= {wdata_i[7:1], 1'b0}; // RQ2
      if (wr_dev && addr_i == `UEPSET_ALARM_IN_H) alarm_in_q[15:8] <= wdata_i; // RQ2
      if (wr_dev && addr_i == `UEPSET_ALARM_OUT_L) alarm_out_q[7:0] <= {wdata_i[7:1], 1'b0};
      if (wr_dev && addr_i == `UEPSET_ALARM_OUT_H) alarm_out_q[15:8] <= wdata_i;
      nak_stat_q <= nak_d; // RQ3
      rdata_q <= read_i ? rd_mux : 8'h00;
    end
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      c_st_h_q    <= 8'h00;
      c_st_l_q    <= 8'h00;
      c_end_h_q   <= 8'h00;
      c_end_l_q   <= 8'h00;
      c_join_q    <= 1'b0; // RQ19
      c_cleared_q <= 1'b0;
    end else begin
      if (c_wr && c_reg == `UEPSET_ST_H) c_st_h_q <= wdata_i;
      if (c_wr && c_reg == `UEPSET_ST_L) c_st_l_q <= wdata_i;
      if (c_wr && c_reg == `UEPSET_END_H) c_end_h_q <= wdata_i;
      if (c_wr && c_reg == `UEPSET_END_L) c_end_l_q <= wdata_i;
      if (c_wr && c_reg >= `UEPSET_ST_H && c_reg <= `UEPSET_END_L) begin
        c_cleared_q <= 1'b0; // RQ7
        c_join_q    <= 1'b0;
      end else if (c_clr) begin
        c_cleared_q <= 1'b1;
      end
      if (c_wr && c_reg == `UEPSET_JOIN) c_join_q <= wdata_i[0] & (c_clr | c_cleared_q); // RQ7
    end
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ans_q   <= UEPSET_ANS_NONE;
      slot_q  <= 3'h0;
      clr_q   <= '0;
      alarm_q <= 1'b0;
    end else begin
      ans_q   <= go_w ? UEPSET_ANS_GO : (nak_w ? UEPSET_ANS_NAK : UEPSET_ANS_NONE); // RQ1
      slot_q  <= (token_i && !is_ctrl) ? hit_idx : 3'h0;
      for (int i = 0; i < NUM_EP; i++) begin
        clr_q[i] <= wr_dev && in_ep_win && !ctrl_win && ep_sel == 5'(i + 1)
                    && ep_reg == `UEPSET_JOIN && wdata_i[1];
      end
      alarm_q <= alarm_w;
    end
  end
  assign rdata_o       = rdata_q;
  assign ans_go_o      = ans_q == UEPSET_ANS_GO;
  assign ans_nak_o     = ans_q == UEPSET_ANS_NAK;
  assign ans_slot_o    = slot_q;
  assign ctrl_in_dir_o = ctrl_dir_q;
  assign ctrl_joined_o = c_join_q;
  assign area_clear_o  = clr_q;
  assign alarm_o       = alarm_q;
  // Assertions.
  property p_nak_unactive;
    @(posedge clock_i) disable iff (rst_i)
      (dev_mode && token_i && token_ep_i != 4'h0 && !hit_any) |=> ans_nak_o && alarm_o;
  endproperty
  a_nak_unactive: assert property (p_nak_unactive) else $error("inactive endpoint not NAKed"); // RQ3
  property p_unjoined_nak;
    @(posedge clock_i) disable iff (rst_i)
      (dev_mode && token_i && hit_any && !join_w[hit_slot]) |=> ans_nak_o && nak_stat_q[0];
  endproperty
  a_unjoined_nak: assert property (p_unjoined_nak) else $error("unjoined endpoint moved data"); // RQ18
  property p_ctrl_join;
    @(posedge clock_i) disable iff (rst_i)
      (token_i && token_ep_i == 4'h0 && !c_join_q) |=> !ans_go_o;
  endproperty
  a_ctrl_join: assert property (p_ctrl_join) else $error("control data before join"); // RQ7
  property p_role;
    @(posedge clock_i) disable iff (rst_i)
      (!dev_mode) |=> !ans_go_o && !ans_nak_o;
  endproperty
  a_role: assert property (p_role) else $error("answer outside device role"); // RQ17
  property p_reset;
    @(posedge clock_i) rst_i |=> !c_join_q && join_w == '0 && en_w == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("joins survive reset"); // RQ19
  property p_go_match;
    @(posedge clock_i) disable iff (rst_i)
      (token_i && token_ep_i != 4'h0) ##1 ans_go_o |-> ans_slot_o != 3'h0;
  endproperty
  a_go_match: assert property (p_go_match) else $error("go without slot match"); // RQ11
  property p_unused_join;
    @(posedge clock_i) disable iff (rst_i)
      (en_w == '0) |=> (join_w == '0) ##1 ((join_w == '0) || ($past(en_w) != '0));
  endproperty
  a_unused_join: assert property (p_unused_join) else $error("unused endpoint joined"); // RQ15
  property p_alarm_sticky;
    @(posedge clock_i) disable iff (rst_i)
      alarm_w |=> nak_stat_q[2] ##1 (nak_stat_q[2] || $past(nak_clr_w));
  endproperty
  a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm flag lost"); // RQ3
  sequence s_token_seen;
    dev_mode && token_i;
  endsequence
  sequence s_one_answer;
    ans_go_o ^ ans_nak_o;
  endsequence
  property p_one_answer;
    @(posedge clock_i) disable iff (rst_i)
      s_token_seen |=> s_one_answer;
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("token answer not single"); // RQ3
  property p_no_token;
    @(posedge clock_i) disable iff (rst_i)
      (!token_i) |=> !ans_go_o && !ans_nak_o;
  endproperty
  a_no_token: assert property (p_no_token) else $error("answer without token"); // RQ1
  sequence s_slot_clear;
    wr_dev && in_ep_win && ep_sel >= 5'h01 && ep_sel <= 5'(NUM_EP)
      && ep_reg == `UEPSET_JOIN && wdata_i[1];
  endsequence
  property p_clear_pulse;
    @(posedge clock_i) disable iff (rst_i)
      s_slot_clear |=> $onehot(area_clear_o);
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("area clear pulse missing"); // RQ7
  property p_clear_idle;
    @(posedge clock_i) disable iff (rst_i)
      (!write_i) |=> area_clear_o == '0;
  endproperty
  a_clear_idle: assert property (p_clear_idle) else $error("area clear without write"); // RQ7
  property p_read_host;
    @(posedge clock_i) disable iff (rst_i)
      (read_i && !dev_mode && addr_i != `UEPSET_ROLE) |=> rdata_o == 8'h00;
  endproperty
  a_read_host: assert property (p_read_host) else $error("setup read in host role"); // RQ17
  property p_ctrl_dir;
    @(posedge clock_i) disable iff (rst_i)
      (wr_dev && addr_i == `UEPSET_CTRL_DIR) |=> ctrl_in_dir_o == $past(wdata_i[0]);
  endproperty
  a_ctrl_dir: assert property (p_ctrl_dir) else $error("control direction not taken"); // RQ4
endmodule

//--- sim/uepset_host_model.sv
// Token source that stands in for the USB host on the far side of the endpoint setup block.
// Assumes the block samples a token on a rising edge and answers in the next cycle.
`timescale 1ns/1ps
module uepset_host_model (
  input  wire logic       clock_i,
  output logic            token_o,
  output logic      [3:0] ep_o,
  output logic            in_o
);
  initial begin
    token_o = 1'b0;
    ep_o    = 4'h0;
    in_o    = 1'b0;
  end

  // Any of the sixteen endpoint numbers in either direction may be addressed.
  task automatic issue(input logic [3:0] ep, input logic dir, input int gap);
    repeat (gap) @(posedge clock_i);
    @(posedge clock_i);
    token_o <= 1'b1;
    ep_o    <= ep;
    in_o    <= dir;
    @(posedge clock_i);
    token_o <= 1'b0;
    // Released lines flip so that a stale value never passes for a fresh one.
    ep_o    <= ~ep;
    in_o    <= ~dir;
  endtask
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the endpoint setup block with a host token model.
// Assumes the block's register map and a one-cycle answer to each token.
`timescale 1ns/1ps
module tb_top;
  logic       clock_i, rst_i, write_i, read_i, ans_go_o, ans_nak_o;
  logic       ctrl_in_dir_o, ctrl_joined_o, alarm_o, token_i, token_in_i, cd, cj;
  logic [7:0] addr_i, wdata_i, rdata_o, rv, b;
  logic [3:0] token_ep_i, ep;
  logic [2:0] ans_slot_o;
  logic [4:0] area_clear_o;
  logic [5:1] en, dir, jn;
  logic [3:0] num [1:5];
  int         err_total, compares, seed, k;
  int         ks [5] = '{1, 2, 3, 4, 5};
  logic [3:0] ns [5] = '{4'h7, 4'h5, 4'h2, 4'h9, 4'hF};

  uepset_top #(.NUM_EP(5)) dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
    .token_i(token_i), .token_ep_i(token_ep_i), .token_in_i(token_in_i),
    .ans_go_o(ans_go_o), .ans_nak_o(ans_nak_o), .ans_slot_o(ans_slot_o),
    .ctrl_in_dir_o(ctrl_in_dir_o), .ctrl_joined_o(ctrl_joined_o),
    .area_clear_o(area_clear_o), .alarm_o(alarm_o));
  uepset_host_model host (.clock_i(clock_i), .token_o(token_i), .ep_o(token_ep_i),
    .in_o(token_in_i));

  always #20 clock_i = ~clock_i;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clock_i);
    write_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    read_i <= 1'b0;
    #1;
    chk(rdata_o & m, exp, "register read");
  endtask
  // Firmware view of the answer: control pipe, matching slot, otherwise alarm.
  function automatic logic [5:0] expect_ans(input logic [3:0] e, input logic d);
    if (e == 4'h0) return {cj, !cj, 3'h0, 1'b0};
    for (int i = 1; i <= 5; i++)
      if (en[i] && dir[i] == d && num[i] == e) return {jn[i], !jn[i], 3'(i), 1'b0};
    return {1'b0, 1'b1, 3'h0, 1'b1};
  endfunction
  task automatic tok(input logic [3:0] e, input logic d, input logic [5:0] exp, input int g);
    host.issue(e, d, g);
    #1;
    chk({2'b00, ans_go_o, ans_nak_o, ans_slot_o, alarm_o}, {2'b00, exp}, "token answer");
  endtask
  task automatic conclude();
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    conclude();
  end

  initial begin
    clock_i = 1'b0;
    rst_i = 1'b1;
    {write_i, read_i, addr_i, wdata_i, cd, cj, en, dir, jn} = '0;
    for (int i = 1; i <= 5; i++) num[i] = 4'h0;
    seed = 32'h4315;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    chk({ctrl_joined_o, ctrl_in_dir_o, area_clear_o, alarm_o}, 8'h00, "reset outputs");
    chk({ans_go_o, ans_nak_o, ans_slot_o, 3'h0}, 8'h00, "reset answer");
    chk(rdata_o, 8'h00, "reset read data");
    rd_chk(8'h01, 8'hFF, 8'h00);
    tok(4'h0, 1'b0, 6'h00, 0);
    wr(8'h00, 8'h01);
    rd_chk(8'h01, 8'hFF, 8'h40);
    rd_chk(8'h0C, 8'hFF, 8'h00);
    rv = 8'($random(seed));
    wr(8'h04, rv);
    rd_chk(8'h04, 8'hFF, rv & 8'hFE);
    wr(8'h06, rv);
    rd_chk(8'h06, 8'hFF, rv & 8'hFE);
    wr(8'h01, 8'h40);
    wr(8'h02, 8'h01);
    cd = 1'b1;
    #1;
    chk({7'h00, ctrl_in_dir_o}, 8'h01, "control direction");
    tok(4'h0, cd, expect_ans(4'h0, cd), 0);
    wr(8'h45, 8'h00);
    wr(8'h46, 8'h7F);
    wr(8'h47, 8'h03);
    cj = 1'b1;
    #1;
    chk({7'h00, ctrl_joined_o}, 8'h01, "control joined");
    tok(4'h0, cd, expect_ans(4'h0, cd), 1);
    for (int s = 0; s < 5; s++) begin
      k = ks[s];
      b = 8'h10 + 8'(8 * k);
      wr(b + 8'h07, 8'h03);
      rd_chk(b + 8'h07, 8'h01, 8'h00);
      dir[k] = 1'($random(seed));
      wr(b, {dir[k], 1'b1, 1'b0, k == 5, ns[s]});
      rd_chk(b, 8'hFF, {dir[k], 1'b1, 1'b0, k == 5, ns[s]});
      wr(b + 8'h01, 8'h00);
      wr(b + 8'h02, 8'h40);
      wr(b + 8'h03, 8'(k));
      wr(b + 8'h05, 8'(k));
      wr(b + 8'h06, 8'h7F);
      en[k] = 1'b1;
      num[k] = ns[s];
      tok(ns[s], dir[k], expect_ans(ns[s], dir[k]), 0);
      wr(b + 8'h07, 8'h01);
      rd_chk(b + 8'h07, 8'h01, 8'h00);
      wr(b + 8'h07, 8'h02);
      #1;
      chk({3'h0, area_clear_o}, 8'(5'h01 << (k - 1)), "area clear pulse");
      wr(b + 8'h07, 8'h01);
      rd_chk(b + 8'h07, 8'h01, 8'h01);
      jn[k] = 1'b1;
      tok(ns[s], dir[k], expect_ans(ns[s], dir[k]), 0);
      tok(ns[s], !dir[k], expect_ans(ns[s], !dir[k]), 0);
    end
    tok(4'hC, 1'b1, expect_ans(4'hC, 1'b1), 0);
    rd_chk(8'h08, 8'h04, 8'h04);
    wr(8'h08, 8'hFF);
    rd_chk(8'h08, 8'hFF, 8'h00);
    wr(8'h18, 8'h00);
    en[1] = 1'b0;
    jn[1] = 1'b0;
    rd_chk(8'h1F, 8'h01, 8'h00);
    // Random tokens mix prompt and slow arrivals against the programmed slots.
    repeat (80) begin
      ep = 4'($random(seed));
      rv = 8'($random(seed));
      tok(ep, (ep == 4'h0) ? cd : rv[0], expect_ans(ep, (ep == 4'h0) ? cd : rv[0]),
          int'(rv[2:1]));
    end
    // A reset in mid-run must drop the control join and slot 3's join and enable set up above.
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    chk({ctrl_joined_o, ctrl_in_dir_o, area_clear_o, alarm_o}, 8'h00, "mid-run reset");
    wr(8'h00, 8'h01);
    rd_chk(8'h2F, 8'h03, 8'h00);
    rd_chk(8'h28, 8'h40, 8'h00);
    rd_chk(8'h47, 8'h03, 8'h00);
    conclude();
  end
endmodule
